// ==== verilog/pcr_consts.svh ====
// offsets, field positions, reset values and constants of the PHY config register bank
// assumes inclusion by the package and the design modules only
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH

// register indices; byte address is four times the index
`define PCR_IDX_CFG        8'h14
`define PCR_IDX_ERRCNT     8'h15
`define PCR_IDX_BIST       8'h16
`define PCR_IDX_STATUS     8'h17
`define PCR_IDX_IRQ_STAT   8'h1C
`define PCR_IDX_IRQ_MASK   8'h1D

`define PCR_CFG_RST        16'h2947
`define PCR_CFG_WMASK      16'hAF7F
`define PCR_BIST_RST       16'h0000
`define PCR_BIST_WMASK     16'hF0FF
`define PCR_STATUS_RST     16'h0040

// configuration field positions
`define PCR_CFG_PD_EN      15
`define PCR_CFG_INT_POL    13
`define PCR_CFG_ATT_HI     11
`define PCR_CFG_ATT_LO     10
`define PCR_CFG_FB_EN      9
`define PCR_CFG_ENH_EN     8
`define PCR_CFG_10M_EN     6
`define PCR_CFG_CLK_HI     5
`define PCR_CFG_CLK_LO     4
`define PCR_CFG_FDCOL_EN   3
`define PCR_CFG_OLDSCR_EN  2
`define PCR_CFG_MSEMI_EN   1
`define PCR_CFG_SSEMI_EN   0

// self-test and loopback field positions
`define PCR_BIST_GEN_HI    15
`define PCR_BIST_GEN_LO    12
`define PCR_BIST_RXFWD     7
`define PCR_BIST_TXFWD     6
`define PCR_BIST_SEL_HI    5
`define PCR_BIST_SEL_LO    2
`define PCR_BIST_PCS_HI    1
`define PCR_BIST_PCS_LO    0

`define PCR_GEN_RUN        4'hF
`define PCR_GEN_STOP       4'h0
`define PCR_SEL_DIGITAL    4'h1
`define PCR_SEL_ANALOG     4'h2
`define PCR_SEL_EXTERNAL   4'h4
`define PCR_SEL_REVERSE    4'h8
`define PCR_CLK_2M5        2'h0
`define PCR_CLK_25M        2'h1

// status bit positions
`define PCR_ST_GEN_BUSY    9
`define PCR_ST_CORE_PWR    6

// interrupt status width and bit positions
`define PCR_IRQ_W          3
`define PCR_IRQ_RXERR      0
`define PCR_IRQ_FALLBACK   1
`define PCR_IRQ_PDDONE     2

`define PCR_PRBS_SEED      15'h7FFF
`define PCR_CNT_MAX        16'hFFFF
`define PCR_RESP_OKAY      2'h0
`define PCR_RESP_SLVERR    2'h2

`endif

// ==== verilog/pcr_pkg.sv ====
// types shared by the PHY config register bank
// assumes the constants header is on the include path
`include "pcr_consts.svh"
package pcr_pkg;
  typedef enum logic [1:0] {
    PCR_SPD_1G,
    PCR_SPD_100M,
    PCR_SPD_10M
  } pcr_speed_t;
endpackage : pcr_pkg

// ==== verilog/pcr_sync.sv ====
// three-stage synchroniser for pin inputs with a two-stage agreement filter
// assumes asynchronous inputs and one clock aclk
`timescale 1ns/1ps
`default_nettype none
module pcr_sync #(
  parameter int W = 2
) (
  input  wire logic         aclk,     // system clock
  input  wire logic         aresetn,  // synchronous reset, active low
  input  wire logic [W-1:0] pin_in,   // asynchronous pin levels
  output logic      [W-1:0] level_q   // filtered level in the aclk domain
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // stage one feeds stage two only
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= (agree & s3_q) | (~agree & level_q);
    end
  end
endmodule : pcr_sync
`default_nettype wire

// ==== verilog/pcr_regs.sv ====
// PHY configuration, receive error counter and self-test/loopback register bank
// assumes an AXI4-Lite master on aclk and PHY core status on aclk; rx error and
// powered-device result come from pins and are synchronised here
//
// What this block does
// [R1] top config bit enables powered-device detection
// [R2] polarity bit zero: interrupt active high
// [R3] attempt code 0..3 means 1,2,4,8 attempts
// [R4] speed fallback runs only while enabled
// [R5] enhanced mode: fallback without energy on C/D
// [R6] fall to 10M after 1G, 100M failed
// [R7] transmit clock: 2.5MHz, 25MHz or off
// [R8] full-duplex collision only when enabled
// [R9] legacy scrambler auto-selected as 1G master
// [R10] semi-cross enabled in 1G master mode
// [R11] semi-cross enabled in 1G slave mode
// [R12] sixteen-bit receive error count, write-one clears
// [R13] all ones starts pattern, zero stops it
// [R14] reverse loop forwards received packets when set
// [R15] MAC-side loop also transmits to line when set
// [R16] loopback select decoded one-hot
// [R17] software keeps coding loopback zero with select
// [R18] 100TX coding loop points by code
// [R19] 1G coding loop before signal processing
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.svh"
module pcr_regs
  import pcr_pkg::*;
(
  input  wire logic        aclk,                 // 125 MHz clock
  input  wire logic        aresetn,              // synchronous reset, active low
  input  wire logic [11:0] s_axi_awaddr,         // write address
  input  wire logic        s_axi_awvalid,        // write address valid
  output logic             s_axi_awready,        // write address ready
  input  wire logic [31:0] s_axi_wdata,          // write data
  input  wire logic [3:0]  s_axi_wstrb,          // write byte strobes
  input  wire logic        s_axi_wvalid,         // write data valid
  output logic             s_axi_wready,         // write data ready
  output logic [1:0]       s_axi_bresp,          // write response
  output logic             s_axi_bvalid,         // write response valid
  input  wire logic        s_axi_bready,         // write response ready
  input  wire logic [11:0] s_axi_araddr,         // read address
  input  wire logic        s_axi_arvalid,        // read address valid
  output logic             s_axi_arready,        // read address ready
  output logic [31:0]      s_axi_rdata,          // read data
  output logic [1:0]       s_axi_rresp,          // read response
  output logic             s_axi_rvalid,         // read data valid
  input  wire logic        s_axi_rready,         // read data ready
  input  wire logic        rx_error_pin,         // receive error pin, async
  input  wire logic        pd_done_pin,          // powered-device detect finished, async
  input  wire logic        link_fail_1g,         // pulse: 1G link attempt failed
  input  wire logic        link_fail_100m,       // pulse: 100M link attempt failed
  input  wire logic        energy_cd,            // energy seen on pairs C and D
  input  wire logic        op_1g,                // operating at 1G
  input  wire logic        op_100tx,             // operating at 100BASE-TX
  input  wire logic        role_master,          // 1G master role
  input  wire logic        peer_legacy,          // link partner uses legacy coding
  input  wire logic        full_duplex,          // full duplex operation
  input  wire logic        col_raw,              // raw collision from the core
  output logic             powered_device_detect_enable, // detection enable
  output logic             int_pin_q,            // interrupt pin, polarity per config
  output logic             irq,                  // interrupt level, active high
  output pcr_speed_t       speed_target_q,       // speed the fallback logic allows
  output logic             tx_clk_on,            // 1G transmit clock running
  output logic             tx_clk_25m,           // 1G transmit clock at 25 MHz
  output logic             col_out,              // collision to MAC
  output logic             use_old_scrambler,    // legacy scrambler selected
  output logic             semi_cross_en,        // semi-cross handling active
  output logic             prbs_active,          // pattern generator running
  output logic             prbs_bit_q,           // pattern generator serial data
  output logic             loop_digital,         // digital loopback
  output logic             loop_analog,          // analog loopback
  output logic             loop_external,        // external loopback
  output logic             loop_reverse,         // reverse loopback
  output logic             rx_to_mac_en,         // receive data forwarded to MAC
  output logic             tx_to_line_en,        // transmit data forwarded to line
  output logic             pcs_loop_pre_scr,     // 100TX loop before scrambler
  output logic             pcs_loop_post_scr,    // 100TX loop before MLT3
  output logic             pcs_loop_post_mlt3,   // 100TX loop after MLT3
  output logic             pcs_loop_1g           // 1G loop before signal processing
);
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [15:0] msk);
    logic [15:0] nv;
    nv = old;
    if (st[0]) nv[7:0]  = wd[7:0];
    if (st[1]) nv[15:8] = wd[15:8];
    return (nv & msk) | (old & ~msk);
  endfunction : merge
  function automatic logic [15:0] strb_bits(input logic [31:0] wd, input logic [3:0] st);
    return {wd[15:8] & {8{st[1]}}, wd[7:0] & {8{st[0]}}};
  endfunction : strb_bits
  function automatic logic [3:0] attempt_limit(input logic [1:0] code);
    return 4'h1 << code;
  endfunction : attempt_limit
  logic [15:0] cfg_q, cfg_d, bist_q, bist_d, cnt_q, cnt_d;
  logic [`PCR_IRQ_W-1:0] ist_q, ist_d, imask_q, ievt;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        awv_q, wv_q, bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [3:0]  fail_cnt_q, fail_cnt_d;
  pcr_speed_t  speed_d;
  logic        fb_event;
  logic [14:0] lfsr_q;
  logic [1:0]  pin_lvl;
  logic        rx_err_lvl_q, pd_lvl_q;
  pcr_sync #(.W(2)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  ({pd_done_pin, rx_error_pin}),
    .level_q (pin_lvl)
  );
  // write decode
  wire        do_write  = awv_q && wv_q && !bvalid_q;
  wire [7:0]  widx      = awaddr_q[9:2];
  wire        whi_ok    = (awaddr_q[11:10] == 2'h0);
  wire        wr_cfg    = do_write && whi_ok && widx == `PCR_IDX_CFG;
  wire        wr_cnt    = do_write && whi_ok && widx == `PCR_IDX_ERRCNT;
  wire        wr_bist   = do_write && whi_ok && widx == `PCR_IDX_BIST;
  wire        wr_ist    = do_write && whi_ok && widx == `PCR_IDX_IRQ_STAT;
  wire        wr_imask  = do_write && whi_ok && widx == `PCR_IDX_IRQ_MASK;
  wire        wr_stat   = do_write && whi_ok && widx == `PCR_IDX_STATUS;
  wire        w_mapped  = wr_cfg | wr_cnt | wr_bist | wr_ist | wr_imask | wr_stat;
  wire [15:0] wbits     = strb_bits(wdata_q, wstrb_q);
  // read decode
  wire        rd_take   = s_axi_arvalid && !rvalid_q;
  wire [7:0]  ridx      = s_axi_araddr[9:2];
  wire        rhi_ok    = (s_axi_araddr[11:10] == 2'h0);
  wire [15:0] status_v  = `PCR_STATUS_RST | (16'(prbs_active) << `PCR_ST_GEN_BUSY);
  wire        r_mapped  = rhi_ok && (ridx == `PCR_IDX_CFG || ridx == `PCR_IDX_ERRCNT ||
                          ridx == `PCR_IDX_BIST || ridx == `PCR_IDX_STATUS ||
                          ridx == `PCR_IDX_IRQ_STAT || ridx == `PCR_IDX_IRQ_MASK);
  wire [15:0] rsel      = !rhi_ok                      ? 16'h0000 :
                          ridx == `PCR_IDX_CFG         ? cfg_q :
                          ridx == `PCR_IDX_ERRCNT      ? cnt_q :
                          ridx == `PCR_IDX_BIST        ? bist_q :
                          ridx == `PCR_IDX_STATUS      ? status_v :
                          ridx == `PCR_IDX_IRQ_STAT    ? 16'(ist_q) :
                          ridx == `PCR_IDX_IRQ_MASK    ? 16'(imask_q) : 16'h0000;

  assign s_axi_awready = !awv_q;
  assign s_axi_wready  = !wv_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awv_q    <= 1'b0;
      wv_q     <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `PCR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awv_q) begin
        awv_q    <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wv_q) begin
        wv_q    <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        awv_q    <= 1'b0;
        wv_q     <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= w_mapped ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `PCR_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {16'h0000, rsel};
      rresp_q  <= r_mapped ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // pin edges; the filtered levels are already past the synchroniser
  wire rx_err_evt = pin_lvl[0] && !rx_err_lvl_q;
  wire pd_evt     = pin_lvl[1] && !pd_lvl_q;
  // the detection enable drops when the measurement completes; a write wins
  always_comb begin
    cfg_d = cfg_q;
    if (pd_evt) cfg_d[`PCR_CFG_PD_EN] = 1'b0;                         // [R1]
    if (wr_cfg) cfg_d = merge(cfg_q, wdata_q, wstrb_q, `PCR_CFG_WMASK);
  end
  assign bist_d = wr_bist ? merge(bist_q, wdata_q, wstrb_q, `PCR_BIST_WMASK) : bist_q;
  // clear first, then count, so an error in the clearing cycle is kept
  always_comb begin
    cnt_d = wr_cnt ? (cnt_q & ~wbits) : cnt_q;                        // [R12]
    if (rx_err_evt && cnt_d != `PCR_CNT_MAX) cnt_d = cnt_d + 16'h0001;  // [R12]
  end

  assign ievt  = `PCR_IRQ_W'({pd_evt, fb_event, rx_err_evt});
  assign ist_d = (wr_ist ? (ist_q & ~wbits[`PCR_IRQ_W-1:0]) : ist_q) | ievt;
  assign irq   = |(ist_q & imask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q        <= `PCR_CFG_RST;
      bist_q       <= `PCR_BIST_RST;
      cnt_q        <= 16'h0000;
      ist_q        <= '0;
      imask_q      <= '0;
      rx_err_lvl_q <= 1'b0;
      pd_lvl_q     <= 1'b0;
      int_pin_q    <= 1'b0;
    end else begin
      cfg_q        <= cfg_d;
      bist_q       <= bist_d;
      cnt_q        <= cnt_d;
      ist_q        <= ist_d;
      imask_q      <= wr_imask ? wbits[`PCR_IRQ_W-1:0] : imask_q;
      rx_err_lvl_q <= pin_lvl[0];
      pd_lvl_q     <= pin_lvl[1];
      int_pin_q    <= cfg_q[`PCR_CFG_INT_POL] ? !irq : irq;           // [R2]
    end
  end

  // configuration fan-out
  wire       fb_en    = cfg_q[`PCR_CFG_FB_EN];
  wire       enh_en   = cfg_q[`PCR_CFG_ENH_EN];
  wire       to10m_en = cfg_q[`PCR_CFG_10M_EN];
  wire [1:0] clk_sel  = cfg_q[`PCR_CFG_CLK_HI:`PCR_CFG_CLK_LO];
  wire [3:0] att_lim  = attempt_limit(cfg_q[`PCR_CFG_ATT_HI:`PCR_CFG_ATT_LO]); // [R3]

  assign powered_device_detect_enable = cfg_q[`PCR_CFG_PD_EN];        // [R1]
  assign tx_clk_on  = (clk_sel == `PCR_CLK_2M5) || (clk_sel == `PCR_CLK_25M); // [R7]
  assign tx_clk_25m = (clk_sel == `PCR_CLK_25M);                      // [R7]
  assign col_out    = col_raw && (!full_duplex || cfg_q[`PCR_CFG_FDCOL_EN]); // [R8]
  assign use_old_scrambler = cfg_q[`PCR_CFG_OLDSCR_EN] && op_1g && role_master
                             && peer_legacy;                          // [R9]
  assign semi_cross_en = op_1g && (role_master ? cfg_q[`PCR_CFG_MSEMI_EN]  // [R10]
                                               : cfg_q[`PCR_CFG_SSEMI_EN]); // [R11]

  // speed fallback; disabling it returns the target to 1G at once
  always_comb begin
    speed_d    = speed_target_q;
    fail_cnt_d = fail_cnt_q;
    fb_event   = 1'b0;
    if (!fb_en) begin                                                 // [R4]
      speed_d    = PCR_SPD_1G;
      fail_cnt_d = 4'h0;
    end else begin
      case (speed_target_q)
        PCR_SPD_1G: begin
          if (link_fail_1g) begin
            if (enh_en && !energy_cd) begin                           // [R5]
              speed_d    = PCR_SPD_100M;
              fail_cnt_d = 4'h0;
              fb_event   = 1'b1;
            end else if (fail_cnt_q + 4'h1 >= att_lim) begin          // [R3]
              speed_d    = PCR_SPD_100M;
              fail_cnt_d = 4'h0;
              fb_event   = 1'b1;
            end else begin
              fail_cnt_d = fail_cnt_q + 4'h1;
            end
          end
        end
        PCR_SPD_100M: begin
          if (link_fail_100m && to10m_en) begin                       // [R6]
            speed_d  = PCR_SPD_10M;
            fb_event = 1'b1;
          end
        end
        PCR_SPD_10M: speed_d = PCR_SPD_10M;
        default:     speed_d = PCR_SPD_1G;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_target_q <= PCR_SPD_1G;
      fail_cnt_q     <= 4'h0;
    end else begin
      speed_target_q <= speed_d;
      fail_cnt_q     <= fail_cnt_d;
    end
  end

  // pattern generator; undefined codes stop it rather than guess
  wire [3:0] gen_ctl = bist_q[`PCR_BIST_GEN_HI:`PCR_BIST_GEN_LO];
  assign prbs_active = (gen_ctl == `PCR_GEN_RUN);                     // [R13]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q     <= `PCR_PRBS_SEED;
      prbs_bit_q <= 1'b0;
    end else if (prbs_active) begin
      lfsr_q     <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};          // [R13]
      prbs_bit_q <= lfsr_q[14];
    end else begin
      prbs_bit_q <= 1'b0;
    end
  end

  // loopback; a nonzero coding-layer code overrides the select field
  wire [3:0] lsel    = bist_q[`PCR_BIST_SEL_HI:`PCR_BIST_SEL_LO];
  wire [1:0] pcs     = bist_q[`PCR_BIST_PCS_HI:`PCR_BIST_PCS_LO];
  wire       sel_ok  = (pcs == 2'h0);                                 // [R16]
  assign loop_digital  = sel_ok && lsel == `PCR_SEL_DIGITAL;          // [R16]
  assign loop_analog   = sel_ok && lsel == `PCR_SEL_ANALOG;           // [R16]
  assign loop_external = sel_ok && lsel == `PCR_SEL_EXTERNAL;         // [R16]
  assign loop_reverse  = sel_ok && lsel == `PCR_SEL_REVERSE;          // [R16]
  assign rx_to_mac_en  = !loop_reverse || bist_q[`PCR_BIST_RXFWD];    // [R14]
  assign tx_to_line_en = !loop_digital || bist_q[`PCR_BIST_TXFWD];    // [R15]
  assign pcs_loop_pre_scr   = op_100tx && pcs == 2'h1;                // [R18]
  assign pcs_loop_post_scr  = op_100tx && pcs == 2'h2;                // [R18]
  assign pcs_loop_post_mlt3 = op_100tx && pcs == 2'h3;                // [R18]
  assign pcs_loop_1g        = op_1g && pcs[0];                        // [R19]

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_int_polarity: assert property (cfg_q[`PCR_CFG_INT_POL] && irq |=> !int_pin_q) // [R2]
    else $error("interrupt pin not active low");
  a_fallback_off: assert property (!fb_en |=> speed_target_q == PCR_SPD_1G) // [R4]
    else $error("fallback moved while disabled");
  a_enhanced_drop: assert property (fb_en && enh_en && !energy_cd && link_fail_1g // [R5]
    && speed_target_q == PCR_SPD_1G |=> speed_target_q == PCR_SPD_100M && ist_q[1])
    else $error("enhanced fallback missed");
  a_ten_meg: assert property (speed_target_q == PCR_SPD_100M && link_fail_100m && fb_en // [R6]
    && !to10m_en |=> speed_target_q == PCR_SPD_100M)
    else $error("fell to 10M while not allowed");
  a_clock_off: assert property (clk_sel[1] |-> !tx_clk_on && !tx_clk_25m) // [R7]
    else $error("transmit clock not off");
  a_fd_collision: assert property (full_duplex && !cfg_q[3] |-> !col_out) // [R8]
    else $error("collision leaked in full duplex");
  a_err_count: assert property (rx_err_evt && !wr_cnt && cnt_q != `PCR_CNT_MAX // [R12]
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("receive error not counted");
  a_prbs_stop: assert property (gen_ctl == `PCR_GEN_STOP |=> !prbs_bit_q) // [R13]
    else $error("pattern kept running");
  a_loop_onehot: assert property ($onehot0({loop_digital, loop_analog, loop_external, // [R16]
    loop_reverse}))
    else $error("loopback decode not one-hot");
  a_rev_suppress: assert property (loop_reverse && !bist_q[7] |-> !rx_to_mac_en) // [R14]
    else $error("reverse loop data reached the MAC");
  a_write_answer: assert property (do_write |=> s_axi_bvalid)
    else $error("write not answered");

  c_prbs_run: cover property (prbs_active ##1 prbs_active);
  c_fall_10m: cover property (speed_target_q == PCR_SPD_100M ##1 speed_target_q == PCR_SPD_10M);
  c_irq_high: cover property (irq && int_pin_q != irq);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule : pcr_regs
`default_nettype wire

// ==== sim/pcr_core_model.sv ====
// far-side core model: receive error pin and link failure pulses
// assumes calls from the bench just after a rising aclk edge
`timescale 1ns/1ps
`default_nettype none
module pcr_core_model (
  input  wire logic aclk,          // system clock
  output logic      rx_error_pin,  // receive error level
  output logic      link_fail_1g,  // 1G attempt failed
  output logic      link_fail_100m // 100M attempt failed
);
  initial begin
    rx_error_pin = 1'h0;
    link_fail_1g = 1'h0;
    link_fail_100m = 1'h0;
  end
  // four cycles each way so the pin filter sees every edge
  task automatic errs(input int n);
    repeat (n) begin
      rx_error_pin <= 1'h1;
      repeat (4) @(posedge aclk);
      rx_error_pin <= 1'h0;
      repeat (4) @(posedge aclk);
    end
  endtask : errs
  task automatic fail(input logic g);
    link_fail_1g <= g;
    link_fail_100m <= !g;
    @(posedge aclk);
    link_fail_1g <= 1'h0;
    link_fail_100m <= 1'h0;
  endtask : fail
endmodule : pcr_core_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// bench: table of register writes, then reset, fallback, counter, irq
// assumes pcr_regs on aclk and the core model on its pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h want %h", $time, (g), (e)); end end
module tb_top
  import pcr_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0, pd_done_pin = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, energy_cd = 1'h1;
  logic        op_1g = 1'h1, op_100tx = 1'h0, role_master = 1'h1, peer_legacy = 1'h1;
  logic        full_duplex = 1'h1, col_raw = 1'h1, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_error_pin, irq;
  logic        link_fail_1g, link_fail_100m, int_pin_q, powered_device_detect_enable;
  logic        tx_clk_on, tx_clk_25m, col_out, use_old_scrambler, semi_cross_en;
  logic        prbs_active, prbs_bit_q, loop_digital, loop_analog, loop_external;
  logic        loop_reverse, rx_to_mac_en, tx_to_line_en, pcs_loop_pre_scr;
  logic        pcs_loop_post_scr, pcs_loop_post_mlt3, pcs_loop_1g;
  pcr_speed_t  speed_target_q;
  int          mismatches = 0, samples_checked = 0, cycles = 0;
  wire [7:0]   cfg_v = {tx_clk_on, tx_clk_25m, powered_device_detect_enable, col_out,
                        use_old_scrambler, semi_cross_en, 2'h0};
  wire [7:0]   bist_v = {prbs_active, loop_digital, loop_analog, loop_external, loop_reverse,
                         pcs_loop_1g, loop_reverse & rx_to_mac_en, loop_digital & tx_to_line_en};
  wire [4:0]   pcs_v = {prbs_bit_q, pcs_loop_pre_scr, pcs_loop_post_scr, pcs_loop_post_mlt3,
                        pcs_loop_1g};
  // {loopback register, written value, expected outputs}
  localparam logic [24:0] ROWS [16] = '{{1'h0, 16'h0000, 8'h80}, {1'h0, 16'h8010, 8'hE0},
    {1'h0, 16'h0020, 8'h00}, {1'h0, 16'h003E, 8'h1C}, {1'h1, 16'hF000, 8'h80},
    {1'h1, 16'h0000, 8'h00}, {1'h1, 16'h0004, 8'h40}, {1'h1, 16'h0044, 8'h41},
    {1'h1, 16'h0008, 8'h20}, {1'h1, 16'h0010, 8'h10}, {1'h1, 16'h0020, 8'h08},
    {1'h1, 16'h00A0, 8'h0A}, {1'h1, 16'h0001, 8'h04}, {1'h1, 16'h0003, 8'h04},
    {1'h1, 16'h0002, 8'h00}, {1'h1, 16'h000C, 8'h00}};
  pcr_regs dut (.*);
  pcr_core_model core (.aclk(aclk), .rx_error_pin(rx_error_pin),
    .link_fail_1g(link_fail_1g), .link_fail_100m(link_fail_100m));
  always #4 aclk = ~aclk;
  task automatic summarize();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic rst();
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask : rst
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic aw, w, ta, tw;
    aw = 1'h1;
    w = 1'h1;
    {s_axi_awaddr, s_axi_wdata} <= {a, 16'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (aw || w) begin
      @(negedge aclk);
      ta = aw & s_axi_awready;
      tw = w & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      aw = aw & !ta;
      w = w & !tw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    resp_q = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [15:0] e);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (!s_axi_rvalid);
    {rd_q, resp_q} = {s_axi_rdata, s_axi_rresp};
    @(posedge aclk);
    s_axi_rready <= 1'h0;
    `CHK(rd_q, {16'h0, e})
  endtask : rc
  task automatic fchk(input logic g, input pcr_speed_t e);
    core.fail(g);
    repeat (2) @(negedge aclk);
    `CHK(speed_target_q, e)
    @(posedge aclk);
  endtask : fchk
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (ROWS[i]) begin
      wr(ROWS[i][24] ? 12'h058 : 12'h050, ROWS[i][23:8]);
      @(negedge aclk);
      if (ROWS[i][24]) `CHK(bist_v, ROWS[i][7:0])
      else `CHK(cfg_v, ROWS[i][7:0])
      @(posedge aclk);
      rc(ROWS[i][24] ? 12'h058 : 12'h050, ROWS[i][23:8]);
    end
    op_100tx <= 1'h1;
    op_1g <= 1'h0;
    for (int k = 1; k < 4; k++) begin
      wr(12'h058, 16'(k));
      @(negedge aclk);
      `CHK(pcs_v, 5'h08 >> (k - 1))
      @(posedge aclk);
    end
    op_100tx <= 1'h0;
    op_1g <= 1'h1;
    role_master <= 1'h0;
    rst();
    @(negedge aclk);
    `CHK({semi_cross_en, use_old_scrambler}, 2'h2)
    @(posedge aclk);
    rc(12'h050, 16'h2947);
    rc(12'h054, 16'h0000);
    rc(12'h058, 16'h0000);
    rc(12'h05C, 16'h0040);
    rc(12'h000, 16'h0000);
    `CHK(resp_q, 2'h2)
    wr(12'h0FC, 16'hFFFF);
    `CHK(resp_q, 2'h2)
    fchk(1'h1, PCR_SPD_1G);
    wr(12'h050, 16'h0640);
    fchk(1'h1, PCR_SPD_1G);
    fchk(1'h1, PCR_SPD_100M);
    fchk(1'h0, PCR_SPD_10M);
    wr(12'h050, 16'h0140);
    energy_cd <= 1'h0;
    wr(12'h050, 16'h0F40);
    fchk(1'h1, PCR_SPD_100M);
    core.errs(3);
    repeat (8) @(posedge aclk);
    rc(12'h054, 16'h0003);
    `CHK(irq, 1'h0)
    wr(12'h074, 16'h0001);
    @(negedge aclk);
    `CHK({irq, int_pin_q}, 2'h3)
    @(posedge aclk);
    wr(12'h050, 16'h2F40);
    @(negedge aclk);
    `CHK(int_pin_q, 1'h0)
    @(posedge aclk);
    wr(12'h054, 16'hFFFF);
    rc(12'h054, 16'h0000);
    wr(12'h070, 16'h0001);
    @(negedge aclk);
    `CHK(irq, 1'h0)
    summarize();
  end
endmodule : tb_top
`default_nettype wire
